// ==== logic/csp_pkg.sv ====
/*
  Shared constants for the slave serial channel: register map, field
  positions, reset values and transfer states.
  Assumes a 32-bit APB with byte addresses and word-aligned registers.
*/
package csp_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_COMM = 8'h04;
  localparam logic [7:0] OFS_HALT = 8'h08;
  localparam logic [7:0] OFS_GO = 8'h0C;
  localparam logic [7:0] OFS_ERRCLR = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_PRIO_LO = 8'h18;
  localparam logic [7:0] OFS_PRIO_HI = 8'h1C;
  localparam logic [7:0] OFS_RXDATA = 8'h20;
  localparam logic [7:0] OFS_TXDATA = 8'h24;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h28;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h2C;
  localparam logic [7:0] OFS_IRQ_EN = 8'h30;
  // Mode register fields
  localparam int unsigned F_OPCLK = 15;
  localparam int unsigned F_XCLK = 14;
  localparam int unsigned F_STSRC = 8;
  localparam int unsigned F_MD_HI = 2;
  localparam int unsigned F_MD_LO = 1;
  localparam int unsigned F_INTSRC = 0;
  localparam logic [15:0] MODE_WMASK = 16'hC107;
  localparam logic [15:0] MODE_FIXED = 16'h0020;
  localparam logic [15:0] MODE_RESET = 16'h0020;
  // Communication register fields
  localparam int unsigned F_TXE = 15;
  localparam int unsigned F_RXE = 14;
  localparam int unsigned F_DAP = 13;
  localparam int unsigned F_CKP = 12;
  localparam int unsigned F_DIR = 7;
  localparam int unsigned F_DLS_HI = 1;
  localparam int unsigned F_DLS_LO = 0;
  localparam logic [15:0] COMM_WMASK = 16'hF083;
  localparam logic [15:0] COMM_FIXED = 16'h0004;
  localparam logic [15:0] COMM_RESET = 16'h0007;
  // Trigger, priority and status fields
  localparam int unsigned F_HALT = 0;
  localparam int unsigned F_GO = 0;
  localparam int unsigned F_PECT = 1;
  localparam int unsigned F_OVCT = 0;
  localparam int unsigned F_PRIO = 5;
  localparam int unsigned F_ST_OVF = 0;
  localparam int unsigned F_ST_PEF = 1;
  localparam int unsigned F_ST_OPER = 2;
  localparam int unsigned F_ST_BUSY = 3;
  localparam int unsigned F_ST_RXFULL = 4;
  // Interrupt bits
  localparam int unsigned IRQ_W = 2;
  localparam int unsigned IRQ_CHAN = 0;
  localparam int unsigned IRQ_OVR = 1;
  // Encodings
  localparam logic [1:0] MD_CSI = 2'b00;
  localparam logic [1:0] DLS_7 = 2'b10;
  localparam logic [1:0] DLS_8 = 2'b11;
  localparam logic [3:0] LEN_7 = 4'h7;
  localparam logic [3:0] LEN_8 = 4'h8;
  typedef enum logic [1:0] {
    CSP_OFF = 2'b00,
    CSP_WAIT = 2'b01,
    CSP_XFER = 2'b11
  } csp_state_t;
endpackage : csp_pkg

// ==== logic/csp_edge_if.sv ====
/*
  Strobes from the serial clock edge finder to the channel core.
  Assumes both ends run on core_clk.
*/
`timescale 1ns/1ns
interface csp_edge_if;
  logic sample_stb;
  logic shift_stb;
  modport src (output sample_stb, output shift_stb);
  modport dst (input sample_stb, input shift_stb);
endinterface : csp_edge_if

// ==== logic/csp_sck_edge.sv ====
/*
  Finds edges of the master's serial clock and splits them into sample
  and shift strobes by phase type. Assumes the pin is synchronous to core_clk.
*/
`timescale 1ns/1ns
module csp_sck_edge (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic sck_in,
  input wire logic dap,
  input wire logic ckp,
  csp_edge_if.src edges
);
  logic sck_prev_reg;
  logic sck_prev_next;
  logic rise;
  logic fall;

  always_comb begin
    sck_prev_next = sck_in;
    rise = sck_in & ~sck_prev_reg;
    fall = ~sck_in & sck_prev_reg;
    // Types 1 and 4 sample on rising edges, 2 and 3 on falling
    edges.sample_stb = (dap ^ ckp) ? fall : rise;
    edges.shift_stb = (dap ^ ckp) ? rise : fall;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sck_prev_reg <= 1'b1;
    end else begin
      sck_prev_reg <= sck_prev_next;
    end
  end
endmodule : csp_sck_edge

// ==== logic/csp_irq_bank.sv ====
/*
  Sticky event bits, write-one-to-clear, enable mask and one level
  interrupt. Assumes single-cycle event pulses and write strobes.
*/
`timescale 1ns/1ns
module csp_irq_bank #(
  parameter int unsigned W = 2
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [W-1:0] events,
  input wire logic clr_wr,
  input wire logic en_wr,
  input wire logic [W-1:0] wdata,
  output logic [W-1:0] status,
  output logic [W-1:0] enable,
  output logic irq
);
  logic [W-1:0] status_next;
  logic [W-1:0] enable_next;
  logic irq_next;

  always_comb begin
    // Set wins over a clear in the same cycle
    status_next = (status & ~(clr_wr ? wdata : '0)) | events;
    enable_next = en_wr ? wdata : enable;
    irq_next = |(status_next & enable_next);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      status <= '0;
      enable <= '0;
      irq <= 1'b0;
    end else begin
      status <= status_next;
      enable <= enable_next;
      irq <= irq_next;
    end
  end
endmodule : csp_irq_bank

// ==== logic/csp_channel.sv ====
/*
  One serial channel running as a three-wire clocked slave, with its mode,
  communication, trigger, priority and error registers on APB.
  Assumes the master's serial clock and data pins are synchronous to
  core_clk and change at most once every two core cycles.
*/
`timescale 1ns/1ns
// How it works
// - Writing 1 to halt bit clears operating flag and stops transfers.
// - Writing 1 to go bit sets operating flag, channel waits for frame.
// - Priority level code is one bit from each priority register, 0 highest.
// - Writing 1 to parity clear bit clears parity error flag.
// - Writing 1 to overrun clear bit clears overrun error flag.
// - Operation clock select picks prescaler clock a or b.
// - Transfer clock select: divided operation clock, or external serial clock pin; here frames run only on the pin clock.
// - Start source: software only, or receive pin edge.
// - Mode field: CSI, UART, simplified I2C; 11 prohibited. Here only CSI runs frames; the other codes are refused.
// - Interrupt source: transfer end or buffer empty.
// - Transmit and receive enables select off, rx, tx or both.
// - Data and clock phase bits pick one of four timing types.
// - Bit order: MSB first or LSB first, both directions.
// - Length field: 10 seven bits, 11 eight bits, others refused.
module csp_channel
  import csp_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_clock_pin,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_out_en,
  input wire logic prescaler_clock_a,
  input wire logic prescaler_clock_b,
  output logic operation_clock_tick,
  output logic channel_operating_flag,
  output logic [1:0] xfer_end_priority,
  output logic irq
);
  csp_edge_if edge_bus ();

  logic [15:0] mode_reg;
  logic [15:0] mode_next;
  logic [15:0] comm_reg;
  logic [15:0] comm_next;
  logic prio_lo_reg;
  logic prio_lo_next;
  logic prio_hi_reg;
  logic prio_hi_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic pready_reg;
  logic pready_next;
  logic pslverr_reg;
  logic pslverr_next;
  logic [1:0] prio_out_reg;
  logic [1:0] prio_out_next;
  logic tick_reg;
  logic tick_next;

  csp_state_t state_reg;
  csp_state_t state_next;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic [7:0] txsh_reg;
  logic [7:0] txsh_next;
  logic [7:0] rxsh_reg;
  logic [7:0] rxsh_next;
  logic [7:0] txbuf_reg;
  logic [7:0] txbuf_next;
  logic txfull_reg;
  logic txfull_next;
  logic [7:0] rxdata_reg;
  logic [7:0] rxdata_next;
  logic rxfull_reg;
  logic rxfull_next;
  logic ovf_reg;
  logic ovf_next;
  logic pef_reg;
  logic pef_next;
  logic so_reg;
  logic so_next;
  logic so_en_reg;
  logic so_en_next;
  logic oper_reg;
  logic oper_next;
  logic si_prev_reg;
  logic si_prev_next;

  logic access;
  logic wr;
  logic rd;
  logic mapped;
  logic halt_wr;
  logic go_wr;
  logic errclr_wr;
  logic irq_clr_wr;
  logic irq_en_wr;
  logic rx_rd;
  logic tx_wr;
  logic [1:0] op_mode;
  logic [1:0] dls;
  logic len_ok;
  logic len7;
  logic [3:0] frame_len;
  logic dir_lsb;
  logic frame_ok;
  logic frame_done;
  logic buf_load;
  logic ovr_event;
  logic [IRQ_W-1:0] irq_events;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_enable;
  logic [7:0] rx_shifted;
  logic [7:0] rx_aligned;

  function automatic logic out_bit(input logic [7:0] sh, input logic lsb, input logic l7);
    if (lsb) begin
      out_bit = sh[0];
    end else if (l7) begin
      out_bit = sh[6];
    end else begin
      out_bit = sh[7];
    end
  endfunction : out_bit

  csp_sck_edge u_edge (
    .core_clk(core_clk),
    .rst(rst),
    .sck_in(serial_clock_pin),
    .dap(comm_reg[F_DAP]),
    .ckp(comm_reg[F_CKP]),
    .edges(edge_bus.src)
  );

  csp_irq_bank #(
    .W(IRQ_W)
  ) u_irq (
    .core_clk(core_clk),
    .rst(rst),
    .events(irq_events),
    .clr_wr(irq_clr_wr),
    .en_wr(irq_en_wr),
    .wdata(pwdata[IRQ_W-1:0]),
    .status(irq_status),
    .enable(irq_enable),
    .irq(irq)
  );

  // Bus decode; writes and reads take effect on the edge that sees pready
  always_comb begin
    access = psel & penable & pready_reg;
    wr = access & pwrite;
    rd = access & ~pwrite;
    halt_wr = wr & (paddr == OFS_HALT);
    go_wr = wr & (paddr == OFS_GO);
    errclr_wr = wr & (paddr == OFS_ERRCLR);
    irq_clr_wr = wr & (paddr == OFS_IRQ_CLR);
    irq_en_wr = wr & (paddr == OFS_IRQ_EN);
    tx_wr = wr & (paddr == OFS_TXDATA);
    rx_rd = rd & (paddr == OFS_RXDATA);
    case (paddr)
      OFS_MODE, OFS_COMM, OFS_HALT, OFS_GO, OFS_ERRCLR, OFS_STATUS,
      OFS_PRIO_LO, OFS_PRIO_HI, OFS_RXDATA, OFS_TXDATA, OFS_IRQ_STAT,
      OFS_IRQ_CLR, OFS_IRQ_EN: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Configuration fields
  always_comb begin
    op_mode = {mode_reg[F_MD_HI], mode_reg[F_MD_LO]};
    dls = {comm_reg[F_DLS_HI], comm_reg[F_DLS_LO]};
    len7 = (dls == DLS_7);
    len_ok = (dls == DLS_7) || (dls == DLS_8);
    frame_len = len7 ? LEN_7 : LEN_8;
    dir_lsb = comm_reg[F_DIR];
    // Only CSI slave on the pin clock runs here; master clocking is elsewhere
    frame_ok = (op_mode == MD_CSI) && mode_reg[F_XCLK] && len_ok;
  end

  // APB register file
  always_comb begin
    mode_next = mode_reg;
    comm_next = comm_reg;
    prio_lo_next = prio_lo_reg;
    prio_hi_next = prio_hi_reg;
    if (wr && paddr == OFS_MODE) begin
      mode_next = (pwdata[15:0] & MODE_WMASK) | MODE_FIXED;
    end
    if (wr && paddr == OFS_COMM) begin
      comm_next = (pwdata[15:0] & COMM_WMASK) | COMM_FIXED;
    end
    if (wr && paddr == OFS_PRIO_LO) begin
      prio_lo_next = pwdata[F_PRIO];
    end
    if (wr && paddr == OFS_PRIO_HI) begin
      prio_hi_next = pwdata[F_PRIO];
    end
    // First register's bit is the upper digit of the level
    prio_out_next = {prio_lo_next, prio_hi_next};
    tick_next = mode_reg[F_OPCLK] ? prescaler_clock_b : prescaler_clock_a;
    pready_next = psel & penable & ~pready_reg;
    pslverr_next = psel & penable & ~pready_reg & ~mapped;
    prdata_next = 32'h0000_0000;
    if (psel && penable && !pready_reg && !pwrite) begin
      case (paddr)
        OFS_MODE: prdata_next = {16'h0000, mode_reg};
        OFS_COMM: prdata_next = {16'h0000, comm_reg};
        OFS_STATUS: begin
          prdata_next[F_ST_OVF] = ovf_reg;
          prdata_next[F_ST_PEF] = pef_reg;
          prdata_next[F_ST_OPER] = oper_reg;
          prdata_next[F_ST_BUSY] = (state_reg == CSP_XFER);
          prdata_next[F_ST_RXFULL] = rxfull_reg;
        end
        OFS_PRIO_LO: prdata_next[F_PRIO] = prio_lo_reg;
        OFS_PRIO_HI: prdata_next[F_PRIO] = prio_hi_reg;
        OFS_RXDATA: prdata_next = {24'h00_0000, rxdata_reg};
        OFS_IRQ_STAT: prdata_next = {{(32 - IRQ_W){1'b0}}, irq_status};
        OFS_IRQ_EN: prdata_next = {{(32 - IRQ_W){1'b0}}, irq_enable};
        default: prdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode_reg <= MODE_RESET;
      comm_reg <= COMM_RESET;
      prio_lo_reg <= 1'b1;
      prio_hi_reg <= 1'b1;
      prio_out_reg <= 2'h3;
      tick_reg <= 1'b0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      mode_reg <= mode_next;
      comm_reg <= comm_next;
      prio_lo_reg <= prio_lo_next;
      prio_hi_reg <= prio_hi_next;
      prio_out_reg <= prio_out_next;
      tick_reg <= tick_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
    end
  end

  // Received frame alignment; LSB-first 7-bit frames land one place high
  always_comb begin
    rx_shifted = dir_lsb ? {serial_data_in, rxsh_reg[7:1]} : {rxsh_reg[6:0], serial_data_in};
    rx_aligned = (dir_lsb && len7) ? {1'b0, rx_shifted[7:1]} : rx_shifted;
    if (len7) begin
      rx_aligned[7] = 1'b0;
    end
  end

  // Transfer sequencer
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    txsh_next = txsh_reg;
    rxsh_next = rxsh_reg;
    oper_next = oper_reg;
    frame_done = 1'b0;
    buf_load = 1'b0;
    si_prev_next = serial_data_in;
    case (state_reg)
      CSP_OFF: begin
        // Pin-edge start is meant for UART reception
        if (mode_reg[F_STSRC] && si_prev_reg && !serial_data_in) begin
          state_next = CSP_WAIT;
          oper_next = 1'b1;
        end
      end
      CSP_WAIT: begin
        if (frame_ok && edge_bus.sample_stb) begin
          // Types 3 and 4 open the frame on a sample edge
          state_next = CSP_XFER;
          rxsh_next = rx_shifted;
          cnt_next = 4'h1;
        end else if (frame_ok && edge_bus.shift_stb && !comm_reg[F_DAP]) begin
          // Types 1 and 2: first shift edge presents the loaded first bit
          state_next = CSP_XFER;
          cnt_next = 4'h0;
        end
      end
      CSP_XFER: begin
        if (!frame_ok) begin
          state_next = CSP_WAIT;
          cnt_next = 4'h0;
        end else if (edge_bus.sample_stb) begin
          rxsh_next = rx_shifted;
          cnt_next = cnt_reg + 4'h1;
          if (cnt_reg + 4'h1 == frame_len) begin
            frame_done = 1'b1;
            state_next = CSP_WAIT;
            cnt_next = 4'h0;
          end
        end else if (edge_bus.shift_stb) begin
          txsh_next = dir_lsb ? {1'b0, txsh_reg[7:1]} : {txsh_reg[6:0], 1'b0};
        end
      end
      default: begin
        state_next = CSP_OFF;
        cnt_next = 4'h0;
      end
    endcase
    // Reload the shifter between frames so the first bit waits on the pin
    if ((go_wr && pwdata[F_GO]) || frame_done) begin
      txsh_next = txbuf_reg;
      buf_load = txfull_reg;
    end
    if (go_wr && pwdata[F_GO]) begin
      state_next = CSP_WAIT;
      oper_next = 1'b1;
      cnt_next = 4'h0;
    end
    // Halt is checked last so it overrides a start in the same write window
    if (halt_wr && pwdata[F_HALT]) begin
      state_next = CSP_OFF;
      oper_next = 1'b0;
      cnt_next = 4'h0;
    end
  end

  // Data buffers, error flags and pin drive
  always_comb begin
    txbuf_next = tx_wr ? pwdata[7:0] : txbuf_reg;
    txfull_next = tx_wr | (txfull_reg & ~buf_load);
    rxdata_next = rxdata_reg;
    rxfull_next = rxfull_reg & ~rx_rd;
    ovr_event = 1'b0;
    if (frame_done && comm_reg[F_RXE]) begin
      rxdata_next = rx_aligned;
      rxfull_next = 1'b1;
      ovr_event = rxfull_reg & ~rx_rd;
    end
    // A new overrun beats a clear written in the same cycle
    ovf_next = (ovf_reg & ~(errclr_wr & pwdata[F_OVCT])) | ovr_event;
    pef_next = pef_reg & ~(errclr_wr & pwdata[F_PECT]);
    so_next = out_bit(txsh_next, dir_lsb, len7);
    so_en_next = oper_next & comm_reg[F_TXE];
    irq_events[IRQ_CHAN] = mode_reg[F_INTSRC] ? buf_load : frame_done;
    irq_events[IRQ_OVR] = ovr_event;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg <= CSP_OFF;
      cnt_reg <= 4'h0;
      txsh_reg <= 8'h00;
      rxsh_reg <= 8'h00;
      oper_reg <= 1'b0;
      si_prev_reg <= 1'b1;
      txbuf_reg <= 8'h00;
      txfull_reg <= 1'b0;
      rxdata_reg <= 8'h00;
      rxfull_reg <= 1'b0;
      ovf_reg <= 1'b0;
      pef_reg <= 1'b0;
      so_reg <= 1'b0;
      so_en_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      txsh_reg <= txsh_next;
      rxsh_reg <= rxsh_next;
      oper_reg <= oper_next;
      si_prev_reg <= si_prev_next;
      txbuf_reg <= txbuf_next;
      txfull_reg <= txfull_next;
      rxdata_reg <= rxdata_next;
      rxfull_reg <= rxfull_next;
      ovf_reg <= ovf_next;
      pef_reg <= pef_next;
      so_reg <= so_next;
      so_en_reg <= so_en_next;
    end
  end

  always_comb begin
    prdata = prdata_reg;
    pready = pready_reg;
    pslverr = pslverr_reg;
    serial_data_out = so_reg;
    serial_data_out_en = so_en_reg;
    operation_clock_tick = tick_reg;
    channel_operating_flag = oper_reg;
    xfer_end_priority = prio_out_reg;
  end
endmodule : csp_channel

// ==== dv/csp_channel_asserts.sv ====
/*
  Checker for the serial slave channel: APB timing, triggers, priority.
  Assumes one clock domain and the register map of the package.
*/
`timescale 1ns/1ns
module csp_chan_chk
  import csp_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic serial_clock_pin,
  input wire logic serial_data_in,
  input wire logic serial_data_out,
  input wire logic serial_data_out_en,
  input wire logic prescaler_clock_a,
  input wire logic prescaler_clock_b,
  input wire logic operation_clock_tick,
  input wire logic channel_operating_flag,
  input wire logic [1:0] xfer_end_priority,
  input wire logic irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic commit;
  assign commit = psel && penable && pready && pwrite;
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  ready_delay_a: assert property ($rose(penable) && psel |=> pready)
    else $error("pready late");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata outside answer");
  halt_clears_a: assert property (commit && paddr == OFS_HALT && pwdata[F_HALT] |-> ##[1:2] !channel_operating_flag)
    else $error("halt did not clear flag");
  halt_zero_a: assert property (commit && paddr == OFS_HALT && !pwdata[F_HALT] && channel_operating_flag |=> channel_operating_flag)
    else $error("halt zero changed flag");
  go_sets_a: assert property (commit && paddr == OFS_GO && pwdata[F_GO] |-> ##[1:2] channel_operating_flag)
    else $error("go did not set flag");
  prio_lo_a: assert property (commit && paddr == OFS_PRIO_LO |-> ##2 xfer_end_priority[1] == $past(pwdata[F_PRIO], 2))
    else $error("priority bit1 wrong");
  prio_hi_a: assert property (commit && paddr == OFS_PRIO_HI |-> ##2 xfer_end_priority[0] == $past(pwdata[F_PRIO], 2))
    else $error("priority bit0 wrong");
  drive_oper_a: assert property (serial_data_out_en |-> channel_operating_flag || $past(channel_operating_flag))
    else $error("data driven while stopped");
endmodule : csp_chan_chk
bind csp_channel csp_chan_chk i_chk (
  .core_clk(core_clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .serial_clock_pin(serial_clock_pin), .serial_data_in(serial_data_in),
  .serial_data_out(serial_data_out), .serial_data_out_en(serial_data_out_en),
  .prescaler_clock_a(prescaler_clock_a), .prescaler_clock_b(prescaler_clock_b),
  .operation_clock_tick(operation_clock_tick), .irq(irq),
  .channel_operating_flag(channel_operating_flag), .xfer_end_priority(xfer_end_priority)
);

// ==== dv/csp_master_model.sv ====
/*
  Behavioural three-wire serial master that clocks one frame per call.
  Assumes its tasks are called right after a rising core_clk edge.
*/
`timescale 1ns/1ns
module csp_master_model (
  input wire logic core_clk,
  output logic sck,
  output logic mosi,
  input wire logic miso
);
  // Four cycles a half bit, well above the two-cycle minimum
  localparam int HALF = 4;
  initial begin
    sck = 1'b1;
    mosi = 1'b1;
  end
  // Clock rests at the idle level of the phase type between frames
  task automatic park(input logic idle);
    sck <= idle;
    @(posedge core_clk);
  endtask : park
  task automatic frame(input logic [7:0] tx, input int len, input logic lsb,
                       output logic [7:0] rx);
    int b;
    rx = 8'h00;
    for (int i = 0; i < len; i++) begin
      b = lsb ? i : len - 1 - i;
      repeat (HALF) @(posedge core_clk);
      sck <= ~sck;
      mosi <= tx[b];
      repeat (HALF) @(posedge core_clk);
      sck <= ~sck;
      rx[b] = miso;
    end
    repeat (HALF) @(posedge core_clk);
    // Released line shows the inverse so a stale bit cannot pass
    mosi <= ~mosi;
  endtask : frame
endmodule : csp_master_model

// ==== dv/csp_testbench.sv ====
/*
  Self-checking bench for the serial slave channel: registers, priority,
  frames of all phase types, refusals, errors and interrupt.
  Assumes the master model and the bound checker.
*/
`timescale 1ns/1ns
module testbench;
  import csp_pkg::*;
  logic core_clk, rst, psel, penable, pwrite, e;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic pready, pslverr, sck, mosi, sdo, sdo_en, tick, oper, irq, pca, pcb;
  logic [1:0] prio;
  logic [7:0] mrx;
  wire logic miso;
  int errors = 0;
  int total_checks = 0;
  assign miso = sdo_en ? sdo : ~sdo;
  csp_channel i_csp_channel (.core_clk(core_clk), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_clock_pin(sck), .serial_data_in(mosi), .serial_data_out(sdo),
    .serial_data_out_en(sdo_en), .prescaler_clock_a(pca), .prescaler_clock_b(pcb),
    .operation_clock_tick(tick), .channel_operating_flag(oper),
    .xfer_end_priority(prio), .irq(irq));
  csp_master_model u_master (.core_clk(core_clk), .sck(sck), .mosi(mosi), .miso(miso));
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task automatic results();
    if (errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n = 0;
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1 && n++ < 40) @(posedge core_clk);
    // A bus that never answers counts against the run
    if (pready !== 1'b1) errors++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    apb(a, 1'b0, 32'h0);
    cmp(q & m, x);
  endtask : rdc
  task automatic t_regs();
    rdc(OFS_MODE, 32'hFFFFFFFF, {16'h0, MODE_RESET});
    rdc(OFS_COMM, 32'hFFFFFFFF, {16'h0, COMM_RESET});
    cmp({30'h0, prio}, 32'h3);
    rdc(8'h3C, 32'hFFFFFFFF, 32'h0);
    cmp({31'h0, e}, 32'h1);
    wr(OFS_MODE, 32'hFFFFFFFF);
    rdc(OFS_MODE, 32'hFFFFFFFF, {16'h0, MODE_WMASK | MODE_FIXED});
    wr(OFS_COMM, 32'hFFFFFFFF);
    rdc(OFS_COMM, 32'hFFFFFFFF, {16'h0, COMM_WMASK | COMM_FIXED});
  endtask : t_regs
  task automatic t_prio();
    for (int c = 0; c < 4; c++) begin
      wr(OFS_PRIO_LO, {26'h0, c[1], 5'h0});
      wr(OFS_PRIO_HI, {26'h0, c[0], 5'h0});
      cmp({30'h0, prio}, 32'(c));
    end
  endtask : t_prio
  task automatic t_clk();
    pca <= 1'b1;
    pcb <= 1'b0;
    wr(OFS_MODE, 32'h0000_4000);
    repeat (2) @(posedge core_clk);
    cmp({31'h0, tick}, 32'h1);
    wr(OFS_MODE, 32'h0000_C000);
    repeat (2) @(posedge core_clk);
    cmp({31'h0, tick}, 32'h0);
  endtask : t_clk
  task automatic setup(input logic [15:0] md, input logic [15:0] cm, input logic [7:0] tx);
    wr(OFS_HALT, 32'h1);
    wr(OFS_MODE, {16'h0, md});
    wr(OFS_COMM, {16'h0, cm});
    u_master.park(cm[F_DAP] == cm[F_CKP]);
    apb(OFS_RXDATA, 1'b0, 32'h0);
    wr(OFS_TXDATA, {24'h0, tx});
    wr(OFS_GO, 32'h1);
  endtask : setup
  task automatic t_frames();
    logic [15:0] cm [6] = '{16'hC003, 16'hD083, 16'hE002, 16'hF082, 16'h4003, 16'h8003};
    logic [7:0] m;
    int len;
    wr(OFS_IRQ_EN, 32'h1);
    for (int i = 0; i < 6; i++) begin
      len = (cm[i][1:0] == DLS_7) ? 7 : 8;
      m = (len == 7) ? 8'h7F : 8'hFF;
      setup(16'h4000, cm[i], 8'hA5 ^ 8'(i));
      u_master.frame(8'h3C ^ 8'(i), len, cm[i][F_DIR], mrx);
      repeat (3) @(posedge core_clk);
      if (cm[i][F_TXE]) cmp({24'h0, mrx & m}, {24'h0, 8'hA5 ^ 8'(i)} & m);
      cmp({31'h0, sdo_en}, {31'h0, cm[i][F_TXE]});
      apb(OFS_RXDATA, 1'b0, 32'h0);
      if (cm[i][F_RXE]) cmp(q, {24'h0, 8'h3C ^ 8'(i)} & m);
      cmp({31'h0, irq}, 32'h1);
      wr(OFS_IRQ_CLR, 32'h3);
      repeat (3) @(posedge core_clk);
      cmp({31'h0, irq}, 32'h0);
    end
  endtask : t_frames
  task automatic t_overrun();
    setup(16'h4000, 16'hC003, 8'h81);
    repeat (2) u_master.frame(8'h42, 8, 1'b0, mrx);
    wr(OFS_HALT, 32'h0);
    rdc(OFS_STATUS, 32'h7, 32'h5);
    rdc(OFS_IRQ_STAT, 32'h2, 32'h2);
    wr(OFS_ERRCLR, 32'h0);
    rdc(OFS_STATUS, 32'h3, 32'h1);
    wr(OFS_ERRCLR, 32'h2);
    rdc(OFS_STATUS, 32'h3, 32'h1);
    wr(OFS_ERRCLR, 32'h1);
    rdc(OFS_STATUS, 32'h3, 32'h0);
    // Overrun bit stays pending but is masked off
    wr(OFS_IRQ_CLR, 32'h1);
    repeat (3) @(posedge core_clk);
    cmp({31'h0, irq}, 32'h0);
  endtask : t_overrun
  task automatic t_refuse();
    logic [15:0] md [4] = '{16'h0000, 16'h4002, 16'h4006, 16'h4000};
    logic [15:0] cm [4] = '{16'hC003, 16'hC003, 16'hC003, 16'hC001};
    for (int i = 0; i < 4; i++) begin
      setup(md[i], cm[i], 8'h00);
      u_master.frame(8'hFF, 8, 1'b0, mrx);
      rdc(OFS_STATUS, 32'h10, 32'h0);
    end
  endtask : t_refuse
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite} = 3'h0;
    paddr = '0;
    pwdata = 32'h0;
    pca = 1'b0;
    pcb = 1'b0;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    t_regs();
    t_prio();
    t_clk();
    t_frames();
    t_overrun();
    t_refuse();
    results();
  end
  // Whole run is under 1500 cycles; this leaves ample margin
  initial begin
    #1000000;
    errors++;
    results();
  end
endmodule : testbench
